/* logic/plc_conversion.sv */
// two-channel piecewise linear conversion with Avalon-MM configuration
`timescale 1ns/1ps
module plc_conversion #(
  parameter int TICK_CYCLES = plc_pkg::MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [plc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [plc_pkg::NSRC-1:0][plc_pkg::DW-1:0] upstreamOut,
  output logic [plc_pkg::NCH-1:0][plc_pkg::DW-1:0] normalized_output
);
  import plc_pkg::*;

  logic [DW-1:0] px_q [NCH][NPT];
  logic [DW-1:0] px_d [NCH][NPT];
  logic [DW-1:0] py_q [NCH][NPT];
  logic [DW-1:0] py_d [NCH][NPT];
  logic [NPT-1:0] en_q [NCH];
  logic [NPT-1:0] en_d [NCH];
  logic [SEL_W-1:0] sel_q [NCH];
  logic [SEL_W-1:0] sel_d [NCH];
  logic inv_q [NCH];
  logic inv_d [NCH];
  logic [HS_W-1:0] hsMs_q [NCH];
  logic [HS_W-1:0] hsMs_d [NCH];
  logic [DW-1:0] hsY_q [NCH];
  logic [DW-1:0] hsY_d [NCH];
  logic waitReq_q, waitReq_d;
  logic [31:0] rdData_q, rdData_d;
  logic [TICK_W-1:0] tick_q, tick_d;
  logic msTick_q, msTick_d;
  logic [DW-1:0] chY [NCH];
  logic [DW-1:0] chX [NCH];

  logic chSel;
  logic [3:0] pIdx;
  logic [7:0] off;
  logic [31:0] rdVal;
  logic [31:0] wMask;
  logic [31:0] wVal;
  logic [DW-1:0] newX;

  function automatic logic [DW-1:0] clampOne(input logic [DW-1:0] v);
    return (v > ONE) ? ONE : v;
  endfunction

  // register file and bus answer
  always_comb begin
    px_d = px_q;
    py_d = py_q;
    en_d = en_q;
    sel_d = sel_q;
    inv_d = inv_q;
    hsMs_d = hsMs_q;
    hsY_d = hsY_q;
    chSel = avs_address[CH_BIT];
    off = avs_address[7:0];
    pIdx = off[5:2];
    rdVal = 32'h0000_0000;
    newX = ZERO;
    if (avs_address[ADDR_W-1] == 1'b0) begin
      if (off[7:6] == GRP_REG) begin
        if (off == OFF_CTRL) begin
          rdVal = {23'h000000, inv_q[chSel], sel_q[chSel]};
        end else if (off == OFF_PT_EN) begin
          rdVal = {21'h000000, en_q[chSel]};
        end else if (off == OFF_HS_MS) begin
          rdVal = {18'h00000, hsMs_q[chSel]};
        end else if (off == OFF_HS_Y) begin
          rdVal = {16'h0000, hsY_q[chSel]};
        end else if (off == OFF_STATUS) begin
          rdVal = {chX[chSel], chY[chSel]};
        end
      end else if (off[7:6] == GRP_PX && pIdx <= 4'(LAST)) begin
        rdVal = {16'h0000, px_q[chSel][pIdx]};
      end else if (off[7:6] == GRP_PY && pIdx <= 4'(LAST)) begin
        rdVal = {16'h0000, py_q[chSel][pIdx]};
      end
    end
    wMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wVal = (rdVal & ~wMask) | (avs_writedata & wMask);
    if (avs_write && !waitReq_q && avs_address[ADDR_W-1] == 1'b0) begin
      if (off == OFF_CTRL) begin
        // R5 source select
        sel_d[chSel] = wVal[SEL_W-1:0];
        // R6 inversion flag
        inv_d[chSel] = wVal[CTRL_INV_BIT];
      end else if (off == OFF_PT_EN) begin
        // R12 end points stay on
        en_d[chSel] = wVal[NPT-1:0] | EN_FIXED;
      end else if (off == OFF_HS_MS) begin
        hsMs_d[chSel] = (wVal[HS_W-1:0] > HS_MAX_MS) ? HS_MAX_MS : wVal[HS_W-1:0];
      end else if (off == OFF_HS_Y) begin
        hsY_d[chSel] = clampOne(wVal[DW-1:0]);
      end else if (off[7:6] == GRP_PX && pIdx >= 4'h1 && pIdx < 4'(LAST)) begin
        // R7 first input read-only
        // R8 clamp to neighbours
        newX = wVal[DW-1:0];
        if (newX < px_q[chSel][pIdx - 4'h1]) begin
          newX = px_q[chSel][pIdx - 4'h1];
        end
        if (newX > px_q[chSel][pIdx + 4'h1]) begin
          newX = px_q[chSel][pIdx + 4'h1];
        end
        px_d[chSel][pIdx] = newX;
      end else if (off[7:6] == GRP_PY && pIdx <= 4'(LAST)) begin
        // R9 limit to one
        py_d[chSel][pIdx] = clampOne(wVal[DW-1:0]);
      end
    end
    // one wait cycle per access; the master holds its request meanwhile
    waitReq_d = 1'b1;
    rdData_d = rdData_q;
    if ((avs_read || avs_write) && waitReq_q) begin
      waitReq_d = 1'b0;
      rdData_d = avs_read ? rdVal : 32'h0000_0000;
    end
    tick_d = tick_q + 17'h00001;
    msTick_d = 1'b0;
    if (tick_q == TICK_W'(TICK_CYCLES - 1)) begin
      tick_d = '0;
      msTick_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < NCH; c++) begin
        for (int i = 0; i < NPT; i++) begin
          // R8 tenths defaults
          px_q[c][i] <= PX_RST[i];
          py_q[c][i] <= ZERO;
        end
        // R2 only end points on
        en_q[c] <= EN_RST;
        sel_q[c] <= '0;
        inv_q[c] <= 1'b0;
        hsMs_q[c] <= '0;
        hsY_q[c] <= ZERO;
      end
      waitReq_q <= 1'b1;
      rdData_q <= 32'h0000_0000;
      tick_q <= '0;
      msTick_q <= 1'b0;
    end else begin
      px_q <= px_d;
      py_q <= py_d;
      en_q <= en_d;
      sel_q <= sel_d;
      inv_q <= inv_d;
      hsMs_q <= hsMs_d;
      hsY_q <= hsY_d;
      waitReq_q <= waitReq_d;
      rdData_q <= rdData_d;
      tick_q <= tick_d;
      msTick_q <= msTick_d;
    end
  end

  assign avs_waitrequest = waitReq_q;
  assign avs_readdata = rdData_q;

  // R11 two independent channels
  for (genvar g = 0; g < NCH; g++) begin : gCh
    plc_state_e st_q, st_d;
    logic [3:0] idx_q, idx_d;
    logic [3:0] lo_q, lo_d;
    logic [DW-1:0] xLat_q, xLat_d;
    logic neg_q, neg_d;
    logic [DW-1:0] quo_q, quo_d;
    logic [DW-1:0] yOut_q, yOut_d;
    logic start_q, start_d;
    logic [NW-1:0] num_q, num_d;
    logic [DW-1:0] den_q, den_d;
    logic [DW-1:0] normalized_input;
    logic [DW-1:0] xCur;
    logic [DW-1:0] dy;
    logic [DW-1:0] ySum;
    logic hsExp;
    plc_div_if divBus ();

    always_comb begin
      // R5 unconnected reads zero
      normalized_input = ZERO;
      if (sel_q[g] != '0 && sel_q[g] <= SEL_W'(NSRC)) begin
        normalized_input = clampOne(upstreamOut[sel_q[g] - 8'h01]);
      end
      // R6 invert before curve
      xCur = inv_q[g] ? ONE - normalized_input : normalized_input;
    end

    always_comb begin
      st_d = st_q;
      idx_d = idx_q;
      lo_d = lo_q;
      xLat_d = xLat_q;
      neg_d = neg_q;
      quo_d = quo_q;
      yOut_d = yOut_q;
      start_d = 1'b0;
      num_d = num_q;
      den_d = den_q;
      dy = ZERO;
      ySum = ZERO;
      unique case (st_q)
        ST_LOAD: begin
          xLat_d = xCur;
          idx_d = 4'h1;
          lo_d = 4'h0;
          st_d = ST_SCAN;
        end
        ST_SCAN: begin
          // R3 skip disabled points
          // R1 search stops at the last point, always on and at full scale
          if (en_q[g][idx_q] && px_q[g][idx_q] >= xLat_q) begin
            neg_d = py_q[g][idx_q] < py_q[g][lo_q];
            dy = neg_d ? py_q[g][lo_q] - py_q[g][idx_q] : py_q[g][idx_q] - py_q[g][lo_q];
            // R4 slope times offset from lower point
            num_d = NW'(dy) * NW'(xLat_q - px_q[g][lo_q]);
            den_d = px_q[g][idx_q] - px_q[g][lo_q];
            if (den_d == ZERO) begin
              quo_d = ZERO;
              st_d = ST_DONE;
            end else begin
              start_d = 1'b1;
              st_d = ST_WAIT;
            end
          end else begin
            if (en_q[g][idx_q]) begin
              lo_d = idx_q;
            end
            idx_d = idx_q + 4'h1;
          end
        end
        ST_WAIT: begin
          if (divBus.done) begin
            quo_d = divBus.quo;
            st_d = ST_DONE;
          end
        end
        ST_DONE: begin
          ySum = neg_q ? py_q[g][lo_q] - quo_q : py_q[g][lo_q] + quo_q;
          yOut_d = clampOne(ySum);
          // R10 hotshot replaces last output
          if (hsExp && xLat_q == ONE) begin
            yOut_d = hsY_q[g];
          end
          st_d = ST_LOAD;
        end
      endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        st_q <= ST_LOAD;
        idx_q <= 4'h1;
        lo_q <= 4'h0;
        xLat_q <= ZERO;
        neg_q <= 1'b0;
        quo_q <= ZERO;
        yOut_q <= ZERO;
        start_q <= 1'b0;
        num_q <= '0;
        den_q <= ZERO;
      end else begin
        st_q <= st_d;
        idx_q <= idx_d;
        lo_q <= lo_d;
        xLat_q <= xLat_d;
        neg_q <= neg_d;
        quo_q <= quo_d;
        yOut_q <= yOut_d;
        start_q <= start_d;
        num_q <= num_d;
        den_q <= den_d;
      end
    end

    assign divBus.start = start_q;
    assign divBus.num = num_q;
    assign divBus.den = den_q;

    plc_div uDiv (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .div(divBus.slave)
    );

    plc_hotshot uHot (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .msTick(msTick_q),
      .atFull(xCur == ONE),
      .delayMs(hsMs_q[g]),
      .expired(hsExp)
    );

    assign chY[g] = yOut_q;
    assign chX[g] = xLat_q;
    assign normalized_output[g] = yOut_q;
  end
endmodule

/* logic/plc_pkg.sv */
// constants and types for the piecewise linear conversion block
// Function
// R1 - curve through at most eleven points, zero..ten
// R2 - per-point enable; 1..9 off, 0 on
// R3 - disabled points are skipped when interpolating
// R4 - output is slope times input plus offset
// R5 - input from selectable upstream output, default none
// R6 - optional input inversion, default not inverted
// R7 - point zero input fixed zero, output configurable
// R8 - inner inputs clamped between neighbours, default tenths
// R9 - point outputs limited to zero..one, default zero
// R10 - hotshot value replaces output after full-scale dwell
// R11 - two independent copies with own configuration
// R12 - last point always on, input fixed one
// R13 - zero delay disables hotshot, timer restarts
package plc_pkg;
  localparam int DW = 16;
  localparam int NW = 2 * DW;
  localparam int NCH = 2;
  localparam int NPT = 11;
  localparam int LAST = 10;
  localparam int NSRC = 8;
  localparam int SEL_W = 8;
  localparam int HS_W = 14;
  localparam int ADDR_W = 10;
  localparam logic [DW-1:0] ONE = 16'h8000;
  localparam logic [DW-1:0] ZERO = 16'h0000;
  localparam logic [HS_W-1:0] HS_MAX_MS = 14'h2710;
  localparam logic [DW-1:0] PX_RST [NPT] = '{16'h0000, 16'h0CCD, 16'h199A, 16'h2666,
    16'h3333, 16'h4000, 16'h4CCD, 16'h599A, 16'h6666, 16'h7333, 16'h8000};
  localparam logic [NPT-1:0] EN_RST = 11'h401;
  localparam logic [NPT-1:0] EN_FIXED = 11'h401;
  // register map, byte offsets inside one channel window
  localparam int CH_BIT = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PT_EN = 8'h04;
  localparam logic [7:0] OFF_HS_MS = 8'h08;
  localparam logic [7:0] OFF_HS_Y = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [1:0] GRP_REG = 2'h0;
  localparam logic [1:0] GRP_PX = 2'h1;
  localparam logic [1:0] GRP_PY = 2'h2;
  localparam int CTRL_INV_BIT = 8;
  localparam int STAT_X_LSB = 16;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 17;
  typedef enum logic [3:0] {
    ST_LOAD = 4'b0001,
    ST_SCAN = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } plc_state_e;
endpackage

/* logic/plc_div_if.sv */
// handshake between a channel sequencer and its divider
`timescale 1ns/1ps
interface plc_div_if;
  logic start;
  logic [plc_pkg::NW-1:0] num;
  logic [plc_pkg::DW-1:0] den;
  logic done;
  logic [plc_pkg::DW-1:0] quo;
  modport master(output start, output num, output den, input done, input quo);
  modport slave(input start, input num, input den, output done, output quo);
endinterface

/* logic/plc_div.sv */
// restoring unsigned divider, one quotient bit per cycle
`timescale 1ns/1ps
module plc_div (
  input wire logic sys_clk,
  input wire logic arst_n,
  plc_div_if.slave div
);
  import plc_pkg::*;
  logic busy_q, busy_d;
  logic [5:0] cnt_q, cnt_d;
  logic [DW:0] rem_q, rem_d;
  logic [NW-1:0] sh_q, sh_d;
  logic [DW-1:0] den_q, den_d;
  logic done_q, done_d;
  logic [DW-1:0] quo_q, quo_d;
  logic [DW:0] remSh;
  logic geq;

  always_comb begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    rem_d = rem_q;
    sh_d = sh_q;
    den_d = den_q;
    done_d = 1'b0;
    quo_d = quo_q;
    remSh = {rem_q[DW-1:0], sh_q[NW-1]};
    geq = remSh >= {1'b0, den_q};
    if (!busy_q) begin
      if (div.start) begin
        busy_d = 1'b1;
        cnt_d = 6'h00;
        rem_d = '0;
        sh_d = div.num;
        den_d = div.den;
      end
    end else begin
      rem_d = geq ? remSh - {1'b0, den_q} : remSh;
      sh_d = {sh_q[NW-2:0], geq};
      cnt_d = cnt_q + 6'h01;
      if (cnt_q == 6'(NW - 1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        // quotient never exceeds the output step, so the low half is exact
        quo_d = {sh_q[DW-2:0], geq};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 6'h00;
      rem_q <= '0;
      sh_q <= '0;
      den_q <= '0;
      done_q <= 1'b0;
      quo_q <= '0;
    end else begin
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      rem_q <= rem_d;
      sh_q <= sh_d;
      den_q <= den_d;
      done_q <= done_d;
      quo_q <= quo_d;
    end
  end

  assign div.done = done_q;
  assign div.quo = quo_q;
endmodule

/* logic/plc_hotshot.sv */
// full-scale dwell timer for the hotshot substitution
`timescale 1ns/1ps
module plc_hotshot (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic msTick,
  input wire logic atFull,
  input wire logic [plc_pkg::HS_W-1:0] delayMs,
  output logic expired
);
  import plc_pkg::*;
  logic [HS_W-1:0] cnt_q, cnt_d;
  logic exp_q, exp_d;

  always_comb begin
    cnt_d = cnt_q;
    // R13 restart on leaving
    if (!atFull) begin
      cnt_d = '0;
    end else if (msTick && cnt_q < delayMs) begin
      cnt_d = cnt_q + 14'h0001;
    end
    // R13 zero delay disables
    exp_d = atFull && (delayMs != '0) && (cnt_q >= delayMs);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;
endmodule

/* bench/plc_partner.sv */
// upstream block model offering normalized values to the converter
`timescale 1ns/1ps
module plc_partner (
  input wire logic sys_clk,
  output logic [plc_pkg::NSRC-1:0][plc_pkg::DW-1:0] upstreamOut
);
  import plc_pkg::*;
  logic [NSRC-1:0][DW-1:0] val_q = '0;
  assign upstreamOut = val_q;
  // source value changes after an edge
  task automatic put(input int i, input logic [DW-1:0] v);
    @(posedge sys_clk);
    val_q[i] <= v;
  endtask
endmodule

/* bench/plc_conversion_checker.sv */
// concurrent checks on the conversion block ports
`timescale 1ns/1ps
module plc_conversion_checker #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [plc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [plc_pkg::NSRC-1:0][plc_pkg::DW-1:0] upstreamOut,
  input wire logic [plc_pkg::NCH-1:0][plc_pkg::DW-1:0] normalized_output
);
  import plc_pkg::*;
  logic rdAns;
  logic [7:0] off;
  assign rdAns = avs_read && !avs_waitrequest && !avs_address[9];
  assign off = avs_address[7:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_req_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  a_wait_one: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer longer than one cycle");
  a_idle_quiet: assert property (
    !(avs_read || avs_write) |=> avs_waitrequest) else $error("answer without request");
  a_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && avs_address[9] |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_ends_on: assert property (
    rdAns && off == OFF_PT_EN |-> avs_readdata[0] && avs_readdata[10])
    else $error("end point disabled");
  a_x_fixed: assert property (
    rdAns && (off == 8'h40 || off == 8'h68)
    |-> avs_readdata == (off == 8'h68 ? 32'h8000 : 32'h0)) else $error("end point x moved");
  a_ctrl_clean: assert property (
    rdAns && off == OFF_CTRL |-> avs_readdata[31:9] == '0) else $error("ctrl spare bits set");
  a_hs_sat: assert property (
    rdAns && off == OFF_HS_MS |-> avs_readdata <= 32'h2710) else $error("hotshot delay too big");
  a_y_range: assert property (
    rdAns && off[7:6] == 2'h2 |-> avs_readdata <= 32'h8000) else $error("point y above one");
  a_out_range: assert property (
    normalized_output[0] <= ONE && normalized_output[1] <= ONE) else $error("output above one");
  cover property (avs_write && !avs_waitrequest);
  cover property (rdAns && off == OFF_STATUS);
  cover property (avs_read && !avs_waitrequest && avs_address[9]);
endmodule
bind plc_conversion plc_conversion_checker #(.TICK_CYCLES(TICK_CYCLES)) i_plc_conversion_checker (
  .sys_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .upstreamOut, .normalized_output);

/* bench/tb_plc_conversion.sv */
// self-checking bench for the two-channel conversion block
`timescale 1ns/1ps
module tb_plc_conversion;
  import plc_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [NSRC-1:0][DW-1:0] upstreamOut;
  logic [NCH-1:0][DW-1:0] normalized_output;
  logic [31:0] rd;
  int mismatches = 0;
  int cmpCount = 0;
  int up[8];
  int mEn[2], mSel[2], mInv[2], mX[2][11], mY[2][11];
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // short ms tick keeps hotshot dwell to tens of cycles
  plc_conversion #(.TICK_CYCLES(10)) i_plc_conversion (.sys_clk, .arst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .upstreamOut, .normalized_output);
  plc_partner i_plc_partner (.sys_clk, .upstreamOut);
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input int a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge sys_clk);
    avs_address <= 10'(a);
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (!avs_waitrequest) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 20) begin
      mismatches++;
      end_sim();
    end
  endtask
  task automatic rchk(input int a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk_reg(rd, e);
  endtask
  task automatic src(input int i, input int v);
    up[i] = v;
    i_plc_partner.put(i, DW'(v));
  endtask
  // model input: select, clamp to one, optional inversion
  function automatic int mx(input int c);
    int x;
    x = (mSel[c] >= 1 && mSel[c] <= 8) ? up[mSel[c] - 1] : 0;
    if (x > 32768) x = 32768;
    if (mInv[c] != 0) x = 32768 - x;
    return x;
  endfunction
  function automatic int my(input int c);
    int x, lo, hi;
    x = mx(c);
    lo = -1;
    hi = -1;
    for (int i = 0; i < 11; i++) begin
      if (mEn[c][i] && mX[c][i] < x) lo = i;
      if (mEn[c][i] && mX[c][i] >= x && hi < 0) hi = i;
    end
    if (lo < 0) return mY[c][hi];
    if (mX[c][hi] == mX[c][lo]) return mY[c][lo];
    return mY[c][lo] + (mY[c][hi] - mY[c][lo]) * (x - mX[c][lo]) / (mX[c][hi] - mX[c][lo]);
  endfunction
  task automatic chk_out(input int c);
    chk_reg(32'(normalized_output[c]), 32'(my(c)));
    rchk((c << 8) + OFF_STATUS, {16'(mx(c)), 16'(my(c))});
  endtask
  task automatic cfg(input int c);
    bus(1'b1, (c << 8) + OFF_CTRL, 32'(mSel[c] + (mInv[c] << 8)), 4'hF);
    bus(1'b1, (c << 8) + OFF_PT_EN, 32'(mEn[c]), 4'hF);
    for (int i = 0; i < 11; i++) bus(1'b1, (c << 8) + 'h80 + 4 * i, 32'(mY[c][i]), 4'hF);
  endtask
  initial begin
    void'($urandom(71));
    for (int c = 0; c < 2; c++) begin
      mEn[c] = 'h401;
      mSel[c] = 0;
      mInv[c] = 0;
      for (int i = 0; i < 11; i++) begin
        mX[c][i] = PX_RST[i];
        mY[c][i] = 0;
      end
    end
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      rchk((c << 8) + OFF_CTRL, 32'h0);
      rchk((c << 8) + OFF_PT_EN, 32'h401);
      rchk((c << 8) + OFF_HS_MS, 32'h0);
      rchk((c << 8) + OFF_HS_Y, 32'h0);
      for (int i = 0; i < 11; i++) rchk((c << 8) + 'h40 + 4 * i, 32'(PX_RST[i]));
      for (int i = 0; i < 11; i++) rchk((c << 8) + 'h80 + 4 * i, 32'h0);
    end
    $display("test defaults done");
    bus(1'b1, 'h040, 32'h1234, 4'hF);
    rchk('h040, 32'h0);
    bus(1'b1, 'h068, 32'h0, 4'hF);
    rchk('h068, 32'h8000);
    bus(1'b1, 'h054, 32'h7000, 4'hF);
    rchk('h054, 32'h4CCD);
    bus(1'b1, 'h054, 32'h4000, 4'hF);
    rchk('h054, 32'h4000);
    bus(1'b1, 'h08C, 32'hFFFF, 4'hF);
    rchk('h08C, 32'h8000);
    bus(1'b1, 'h08C, 32'h1234, 4'hF);
    bus(1'b1, 'h08C, 32'h0056, 4'h1);
    rchk('h08C, 32'h1256);
    bus(1'b1, OFF_HS_MS, 32'hFFFF, 4'hF);
    rchk(OFF_HS_MS, 32'h2710);
    bus(1'b1, 'h300, 32'h1FF, 4'hF);
    rchk('h100, 32'h0);
    rchk('h200, 32'h0);
    rchk('h014, 32'h0);
    bus(1'b1, OFF_HS_MS, 32'h0, 4'hF);
    $display("test limits done");
    // random curves, both channels configured apart
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 8; i++) src(i, $urandom_range(0, 36864));
      for (int c = 0; c < 2; c++) begin
        mSel[c] = $urandom_range(0, 9);
        mInv[c] = $urandom_range(0, 1);
        mEn[c] = $urandom_range(0, 2047) | 'h401;
        for (int i = 0; i < 11; i++) mY[c][i] = $urandom_range(0, 32768);
        cfg(c);
      end
      // longest computation stays below about fifty cycles
      repeat (120) @(posedge sys_clk);
      chk_out(0);
      chk_out(1);
    end
    $display("test curves done");
    src(0, 32768);
    mSel[0] = 1;
    mInv[0] = 0;
    mEn[0] = 'h401;
    mY[0][10] = 'h2000;
    cfg(0);
    bus(1'b1, OFF_HS_Y, 32'h1234, 4'hF);
    bus(1'b1, OFF_HS_MS, 32'h2, 4'hF);
    repeat (200) @(posedge sys_clk);
    chk_reg(32'(normalized_output[0]), 32'h1234);
    src(0, 'h4000);
    repeat (120) @(posedge sys_clk);
    chk_out(0);
    // a short dip below full scale must restart the dwell, so 20 ms never expires here
    bus(1'b1, OFF_HS_MS, 32'h14, 4'hF);
    src(0, 32768);
    repeat (150) @(posedge sys_clk);
    src(0, 'h4000);
    repeat (30) @(posedge sys_clk);
    src(0, 32768);
    repeat (150) @(posedge sys_clk);
    chk_reg(32'(normalized_output[0]), 32'h2000);
    src(0, 32768);
    bus(1'b1, OFF_HS_MS, 32'h0, 4'hF);
    repeat (120) @(posedge sys_clk);
    chk_reg(32'(normalized_output[0]), 32'h2000);
    $display("test hotshot done");
    end_sim();
  end
endmodule
